// ---- hw/drv_pkg.sv ----
// Constants and types for the octal driver serial frame logic.
// Assumes one mclk domain; no process or wire lives here.
package drv_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned NCH         = 8;
  localparam int unsigned NPAR        = 4;
  localparam int unsigned NPAIR       = 4;
  localparam int unsigned CNT_W       = 4;
  localparam int unsigned SYNC_W      = 30;
  // Command word fields
  localparam int unsigned CMD_EN_LO   = 0;
  localparam int unsigned CMD_OL_LO   = 8;
  // Response word fields
  localparam int unsigned RSP_TW      = 0;
  localparam int unsigned RSP_DRV_LO  = 1;
  localparam int unsigned RSP_PAR_LO  = 9;
  localparam int unsigned RSP_SPARE_LO = 13;
  localparam int unsigned RSP_SPARE_W = 2;
  localparam int unsigned RSP_SUP     = 15;
  // Channels 5 to 8 sit at index 4 to 7
  localparam int unsigned PAR_CH_LO   = 4;
  // Reset values
  localparam logic [WORD_W-1:0] CMD_RST = 16'h0000;
  localparam logic [WORD_W-1:0] RSP_RST = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
  localparam logic [SYNC_W-1:0] SYNC_RST = 30'h0000_0000;

  typedef enum logic [1:0]
  {
    IDLE  = 2'b01,
    SHIFT = 2'b10
  } frame_state_t;
endpackage : drv_pkg

// ---- hw/frame_if.sv ----
// Bundle between the frame core and its serial shifter.
// Assumes both ends run on mclk and share one reset.
`timescale 1ns/1ps
interface frame_if;
  import drv_pkg::*;
  logic              ce;
  logic              sclk;
  logic              sel_n;
  logic              sdi;
  logic [WORD_W-1:0] status_word;
  logic [WORD_W-1:0] rx_word;
  logic              frame_valid;
  logic              sdo;
  logic              sdo_oe;

  modport core
  (
    output ce, sclk, sel_n, sdi, status_word,
    input  rx_word, frame_valid, sdo, sdo_oe
  );
  modport shifter
  (
    input  ce, sclk, sel_n, sdi, status_word,
    output rx_word, frame_valid, sdo, sdo_oe
  );
endinterface : frame_if

// ---- hw/frame_shifter.sv ----
// Serial shifter: 16-bit frames, length check, response shift-out.
// Assumes sclk, sel_n and sdi arrive already synchronised to mclk.
`timescale 1ns/1ps
module frame_shifter
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Link to core
  frame_if.shifter fr
);
  import drv_pkg::*;

  frame_state_t      state_q;
  frame_state_t      state_d;
  logic              sclk_p_q;
  logic              sel_n_p_q;
  logic              in_bit_q;
  logic [WORD_W-1:0] sr_q;
  logic [CNT_W-1:0]  bits_q;
  logic              seen_q;
  logic              valid_q;
  logic              oe_q;

  wire sel_fall = sel_n_p_q & ~fr.sel_n;
  wire sel_rise = ~sel_n_p_q & fr.sel_n;
  wire clk_rise = ~sclk_p_q & fr.sclk & ~fr.sel_n;
  wire clk_fall = sclk_p_q & ~fr.sclk & ~fr.sel_n;
  wire in_shift = (state_q == SHIFT);
  // Multiple of 16 bits, and clock low at deselect
  wire valid_d  = in_shift & sel_rise & seen_q & (bits_q == CNT_ZERO)
                  & ~fr.sclk;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      IDLE:    if (sel_fall) state_d = SHIFT;
      SHIFT:   if (sel_rise) state_d = IDLE;
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_q   <= IDLE;
      sclk_p_q  <= 1'b0;
      sel_n_p_q <= 1'b1;
      oe_q      <= 1'b0;
      valid_q   <= 1'b0;
    end
    else if (fr.ce)
    begin
      state_q   <= state_d;
      sclk_p_q  <= fr.sclk;
      sel_n_p_q <= fr.sel_n;
      oe_q      <= ~fr.sel_n;
      valid_q   <= valid_d;
    end
  end

  // Shifting through one register passes earlier bits on, for chaining
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sr_q     <= RSP_RST;
      in_bit_q <= 1'b0;
    end
    else if (fr.ce)
    begin
      if (sel_fall && !in_shift)
        sr_q <= fr.status_word;
      else if (clk_fall && in_shift)
        sr_q <= {in_bit_q, sr_q[WORD_W-1:1]};
      if (clk_rise)
        in_bit_q <= fr.sdi;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      bits_q <= CNT_ZERO;
      seen_q <= 1'b0;
    end
    else if (fr.ce)
    begin
      if (sel_fall)
      begin
        bits_q <= CNT_ZERO;
        seen_q <= 1'b0;
      end
      else if (clk_rise && in_shift)
      begin
        bits_q <= bits_q + CNT_ONE;
        seen_q <= 1'b1;
      end
    end
  end

  assign fr.rx_word     = sr_q;
  assign fr.frame_valid = valid_q;
  assign fr.sdo         = sr_q[0];
  assign fr.sdo_oe      = oe_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_open;
    fr.ce && !in_shift && sel_fall;
  endsequence

  a_first_bit_lsb: assert property (s_open |=>
    fr.sdo == $past(fr.status_word[RSP_TW]))
    else $error("first response bit is not bit 0");
  a_frame_length: assert property ($rose(valid_q) |->
    $past(bits_q) == CNT_ZERO && $past(seen_q) && !$past(fr.sclk))
    else $error("frame accepted with bad length");
  a_so_idle_off: assert property (fr.ce && fr.sel_n |=> !fr.sdo_oe)
    else $error("serial output driven while deselected");
endmodule : frame_shifter

// ---- hw/octal_driver_spi_frame.sv ----
// Command and status frame core for an eight-channel power driver.
// Assumes pins are asynchronous to mclk; sclk well below mclk/4.
`timescale 1ns/1ps
module octal_driver_spi_frame
(
  // Clock, reset, enable
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  // Serial port pins
  input  wire logic                      sclk,
  input  wire logic                      frame_select_n,
  input  wire logic                      sdi,
  output wire logic                      sdo,
  output wire logic                      sdo_oe,
  // Parallel control inputs
  input  wire logic                      parallel_input_ch5,
  input  wire logic                      parallel_input_ch6,
  input  wire logic                      parallel_input_ch7,
  input  wire logic                      parallel_input_ch8,
  // Fault sense from the analog side
  input  wire logic [drv_pkg::NCH-1:0]   open_load_det,
  input  wire logic [drv_pkg::NCH-1:0]   over_current_det,
  input  wire logic [drv_pkg::NPAIR-1:0] thermal_warning_flag,
  input  wire logic [drv_pkg::NPAIR-1:0] thermal_shutdown_det,
  input  wire logic                      load_supply_fault,
  // Driver controls
  output wire logic [drv_pkg::NCH-1:0]   driver_on,
  output wire logic [drv_pkg::NCH-1:0]   open_load_en
);
  import drv_pkg::*;

  function automatic logic [NCH-1:0] pair_to_ch(input logic [NPAIR-1:0] p);
    logic [NCH-1:0] c;
    c = '0;
    for (int i = 0; i < NPAIR; i++)
    begin
      c[2*i]   = p[i];
      c[2*i+1] = p[i];
    end
    return c;
  endfunction : pair_to_ch

  function automatic logic [NPAIR-1:0] pair_any(input logic [NCH-1:0] c);
    logic [NPAIR-1:0] p;
    p = '0;
    for (int i = 0; i < NPAIR; i++)
      p[i] = c[2*i] | c[2*i+1];
    return p;
  endfunction : pair_any

  frame_if fr ();

  // Two-stage synchronisers; stage one feeds stage two only
  // Select resets high, its idle level, so no false fall follows reset
  logic              sel_m_q;
  logic              sel_s_q;
  logic [SYNC_W-1:0] sync_m_q;
  logic [SYNC_W-1:0] sync_s_q;
  wire  [SYNC_W-1:0] sync_raw =
  {
    sclk, sdi,
    parallel_input_ch8, parallel_input_ch7,
    parallel_input_ch6, parallel_input_ch5,
    open_load_det, over_current_det,
    thermal_warning_flag, thermal_shutdown_det
  };

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sel_m_q  <= 1'b1;
      sel_s_q  <= 1'b1;
      sync_m_q <= SYNC_RST;
      sync_s_q <= SYNC_RST;
    end
    else if (ce)
    begin
      sel_m_q  <= frame_select_n;
      sel_s_q  <= sel_m_q;
      sync_m_q <= sync_raw;
      sync_s_q <= sync_m_q;
    end
  end

  // Supply flag synchronised on its own
  logic sup_m_q;
  logic sup_s_q;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sup_m_q <= 1'b0;
      sup_s_q <= 1'b0;
    end
    else if (ce)
    begin
      sup_m_q <= load_supply_fault;
      sup_s_q <= sup_m_q;
    end
  end

  logic             sclk_s;
  logic             sdi_s;
  logic [NPAR-1:0]  par_s;
  logic [NCH-1:0]   ol_s;
  logic [NCH-1:0]   oc_s;
  logic [NPAIR-1:0] tw_s;
  logic [NPAIR-1:0] tsd_s;

  assign {sclk_s, sdi_s, par_s, ol_s, oc_s, tw_s, tsd_s} = sync_s_q;

  // State
  logic [WORD_W-1:0] cmd_q;
  logic [NCH-1:0]    driver_on_q;
  logic [NCH-1:0]    open_load_en_q;
  logic [NCH-1:0]    oc_q;
  logic [NPAIR-1:0]  tsd_q;
  logic              sup_q;
  logic [NPAR-1:0]   par_cap_q;

  // Decode of the frame just accepted
  wire [WORD_W-1:0] rx      = fr.rx_word;
  wire              valid   = fr.frame_valid;
  wire [NCH-1:0]    rx_en   = rx[CMD_EN_LO +: NCH];
  wire [WORD_W-1:0] cmd_d   = valid ? rx : cmd_q;

  // Driver gating
  wire [NCH-1:0]    tsd_ch   = pair_to_ch(tsd_q);
  wire [NCH-1:0]    blocked  = oc_q | tsd_ch;
  wire [NCH-1:0]    par_mask = {par_s, {PAR_CH_LO{1'b0}}};
  wire [NCH-1:0]    on_d     =
    (cmd_q[CMD_EN_LO +: NCH] | par_mask) & ~blocked;

  // Fault latches; a new fault wins over a clearing frame
  wire [NCH-1:0]    oc_set = oc_s & driver_on_q;
  wire [NCH-1:0]    oc_clr = {NCH{valid}} & ~rx_en;
  wire [NCH-1:0]    oc_d   = oc_set | (oc_q & ~oc_clr);
  wire [NPAIR-1:0]  tsd_clr = {NPAIR{valid}} & ~tsd_s & ~pair_any(rx_en);
  wire [NPAIR-1:0]  tsd_d   = tsd_s | (tsd_q & ~tsd_clr);
  wire              sup_d   = sup_s_q | (sup_q & ~valid);

  // Parallel input snapshot on a new shutdown-class fault
  wire              cap_evt = (|(oc_set & ~oc_q)) | (|(tsd_s & ~tsd_q));
  wire [NPAR-1:0]   cap_d   = cap_evt ? par_s : par_cap_q;
  wire [NPAR-1:0]   par_show = (|blocked) ? par_cap_q : par_s;

  // Open load only seen while off and enabled
  wire [NCH-1:0]    ol_rpt = ol_s & ~driver_on_q & open_load_en_q;
  wire [NCH-1:0]    drv_status = ol_rpt | blocked;
  wire [WORD_W-1:0] status =
  {
    sup_q, {RSP_SPARE_W{1'b0}}, par_show, drv_status, |tw_s
  };

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cmd_q          <= CMD_RST;
      driver_on_q    <= '0;
      open_load_en_q <= '0;
    end
    else if (ce)
    begin
      cmd_q          <= cmd_d;
      driver_on_q    <= on_d;
      open_load_en_q <= cmd_q[CMD_OL_LO +: NCH];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      oc_q      <= '0;
      tsd_q     <= '0;
      sup_q     <= 1'b0;
      par_cap_q <= '0;
    end
    else if (ce)
    begin
      oc_q      <= oc_d;
      tsd_q     <= tsd_d;
      sup_q     <= sup_d;
      par_cap_q <= cap_d;
    end
  end

  assign fr.ce          = ce;
  assign fr.sclk        = sclk_s;
  assign fr.sel_n       = sel_s_q;
  assign fr.sdi         = sdi_s;
  assign fr.status_word = status;

  frame_shifter u_shifter
  (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .fr      (fr.shifter)
  );

  assign sdo          = fr.sdo;
  assign sdo_oe       = fr.sdo_oe;
  assign driver_on    = driver_on_q;
  assign open_load_en = open_load_en_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_cmd_only_valid: assert property (!$stable(cmd_q) |->
    $past(valid && ce))
    else $error("command changed without a valid frame");
  a_cmd_word_load: assert property (ce && valid |=>
    cmd_q == $past(rx))
    else $error("accepted word not latched");
  a_low_drivers: assert property (ce |=>
    driver_on_q[PAR_CH_LO-1:0] ==
    $past(cmd_q[PAR_CH_LO-1:0] & ~blocked[PAR_CH_LO-1:0]))
    else $error("driver 1-4 state wrong");
  a_par_or_serial: assert property (ce && !(|blocked[NCH-1:PAR_CH_LO])
    |=> driver_on_q[NCH-1:PAR_CH_LO] ==
    $past(cmd_q[NCH-1:PAR_CH_LO] | par_s))
    else $error("driver 5-8 not serial OR parallel");
  a_diag_follow: assert property (ce |=>
    open_load_en_q == $past(cmd_q[CMD_OL_LO +: NCH]))
    else $error("open-load enable mismatch");
  a_oc_forces_off: assert property (ce |=>
    (driver_on_q & $past(oc_q)) == '0)
    else $error("driver on while over-current latched");
  a_oc_no_retry: assert property (ce && !valid |=>
    ($past(oc_q) & ~oc_q) == '0)
    else $error("over-current cleared without a frame");
  a_rsp_layout: assert property (
    status[RSP_SPARE_LO +: RSP_SPARE_W] == '0 && status[RSP_SUP] == sup_q
    && status[RSP_TW] == (|tw_s))
    else $error("response layout wrong");
  a_fault_status: assert property (
    (blocked & ~status[RSP_DRV_LO +: NCH]) == '0
    && (status[RSP_DRV_LO +: NCH] & ~blocked & driver_on_q) == '0)
    else $error("driver status bit wrong");
  a_par_capture: assert property (ce && cap_evt |=>
    par_cap_q == $past(par_s) && status[RSP_PAR_LO +: NPAR] == par_cap_q)
    else $error("parallel inputs not captured on fault");
  a_reset_zero: assert property ($past(sys_rst) |->
    cmd_q == CMD_RST && fr.rx_word == RSP_RST)
    else $error("registers not zero after reset");

  sequence s_accept;
    ce && valid;
  endsequence

  // Clock enable low freezes every latch and register
  a_ce_freeze: assert property (!ce |=>
    $stable(cmd_q) && $stable(driver_on_q) && $stable(open_load_en_q)
    && $stable(oc_q) && $stable(tsd_q) && $stable(sup_q)
    && $stable(par_cap_q))
    else $error("state moved while clock enable low");
  a_oc_set_wins: assert property (ce && oc_set != '0 |=>
    (oc_q & $past(oc_set)) == $past(oc_set))
    else $error("over-current set lost");
  a_oc_clear: assert property (s_accept ##0 (oc_set == '0) |=>
    (oc_q & ~$past(rx_en)) == '0)
    else $error("over-current kept on disabled driver");
  a_tsd_set: assert property (ce && tsd_s != '0 |=>
    (tsd_q & $past(tsd_s)) == $past(tsd_s))
    else $error("shutdown latch missed a fault");
  a_tsd_clear: assert property (s_accept ##0 (tsd_s == '0) |=>
    (tsd_q & ~pair_any($past(rx_en))) == '0)
    else $error("shutdown latch kept on disabled pair");
  a_tsd_off: assert property (ce |=>
    (driver_on_q & pair_to_ch($past(tsd_q))) == '0)
    else $error("driver on while its pair is shut down");
  a_sup_set: assert property (ce && sup_s_q |=> sup_q)
    else $error("supply fault not latched");
  a_sup_clear: assert property (s_accept ##0 !sup_s_q |=> !sup_q)
    else $error("supply fault kept after valid frame");
  a_par_live: assert property (!(|blocked) |->
    status[RSP_PAR_LO +: NPAR] == par_s)
    else $error("parallel inputs not mirrored");
  a_cap_hold: assert property (ce && !cap_evt |=>
    par_cap_q == $past(par_cap_q))
    else $error("parallel snapshot moved without a fault");
endmodule : octal_driver_spi_frame

// ---- sim/octal_driver_spi_frame_tb_top.sv ----
// Testbench: frames through the host model, checks drivers and status.
// Assumes the design files, with their own assertions, compile first.
`timescale 1ns/1ps
module octal_driver_spi_frame_tb_top;
  import drv_pkg::*;
  logic             mclk                 = 1'b0;
  logic             sys_rst              = 1'b1;
  logic             ce                   = 1'b1;
  logic [3:0]       par                  = 4'h0;
  logic [NCH-1:0]   open_load_det        = 8'h00;
  logic [NCH-1:0]   over_current_det     = 8'h00;
  logic [NPAIR-1:0] thermal_warning_flag = 4'h0;
  logic [NPAIR-1:0] thermal_shutdown_det = 4'h0;
  logic             load_supply_fault    = 1'b0;
  logic             sclk;
  logic             frame_select_n;
  logic             sdi;
  logic             sdo;
  logic             sdo_oe;
  logic [NCH-1:0]   driver_on;
  logic [NCH-1:0]   open_load_en;
  logic [31:0]      rx;
  int               fails                = 0;
  int               checks_done          = 0;

  always #50 mclk = ~mclk;

  octal_driver_spi_frame dut
  (
    .mclk, .sys_rst, .ce, .sclk, .frame_select_n, .sdi, .sdo, .sdo_oe,
    .parallel_input_ch5(par[0]), .parallel_input_ch6(par[1]),
    .parallel_input_ch7(par[2]), .parallel_input_ch8(par[3]),
    .open_load_det, .over_current_det, .thermal_warning_flag,
    .thermal_shutdown_det, .load_supply_fault, .driver_on, .open_load_en
  );

  spi_host_model host
  (
    .mclk, .sclk, .frame_select_n, .sdi, .sdo, .sdo_oe
  );

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic send(input logic [15:0] cmd);
    host.xfer(32'(cmd), 16, 4, rx);
  endtask : send

  task automatic test_done();
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // Fixed waits cover the pin synchronisers
  task automatic settle();
    repeat (8) @(posedge mclk);
  endtask : settle

  initial
  begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("driver_on", 32'(driver_on), 32'h0);
    chk("open_load_en", 32'(open_load_en), 32'h0);
    chk("sdo_oe", 32'(sdo_oe), 32'h0);
    send(16'ha5c3);
    chk("status", rx, 32'h0000);
    chk("driver_on", 32'(driver_on), 32'h00c3);
    chk("open_load_en", 32'(open_load_en), 32'h00a5);
    for (int i = 0; i < 16; i++)
    begin
      host.xfer(32'h1 << i, 16, (i % 2 == 1) ? 4 : 12, rx);
      chk("cmd_walk", {16'h0, open_load_en, driver_on}, 32'h1 << i);
    end
    // Bad lengths keep the last command word
    for (int n = 0; n < 34; n += 17)
    begin
      host.xfer(32'h0000_00ff, n, 4, rx);
      chk("bad_len", {16'h0, open_load_en, driver_on}, 32'h8000);
    end
    host.xfer(32'h0000_0015, 15, 4, rx);
    chk("bad_len", {16'h0, open_load_en, driver_on}, 32'h8000);
    host.xfer(32'h3c0f_00f0, 32, 4, rx);
    chk("chain_out", rx, 32'h00f0_0000);
    chk("chain_cmd", {16'h0, open_load_en, driver_on}, 32'h3c0f);
    send(16'h000f);
    par <= 4'ha;
    settle();
    chk("par_or", 32'(driver_on), 32'h00af);
    send(16'h000f);
    chk("par_status", rx, 32'h1400);
    par <= 4'h0;
    send(16'hff00);
    open_load_det <= 8'h0f;
    thermal_warning_flag <= 4'h4;
    load_supply_fault <= 1'b1;
    settle();
    send(16'hff00);
    chk("fault_status", rx, 32'h801f);
    open_load_det <= 8'h00;
    thermal_warning_flag <= 4'h0;
    load_supply_fault <= 1'b0;
    settle();
    send(16'hff00);
    chk("supply_latch", rx, 32'h8000);
    send(16'h0001);
    chk("supply_clear", rx, 32'h0000);
    par <= 4'h5;
    over_current_det <= 8'h01;
    settle();
    chk("oc_off", 32'(driver_on), 32'h0050);
    par <= 4'h0;
    over_current_det <= 8'h00;
    settle();
    chk("oc_no_retry", 32'(driver_on), 32'h0000);
    send(16'h0001);
    chk("oc_capture", rx, 32'h0a02);
    chk("oc_held", 32'(driver_on), 32'h0000);
    send(16'h0000);
    chk("oc_status", rx, 32'h0a02);
    send(16'h000c);
    chk("oc_cleared", rx, 32'h0000);
    chk("drv_back", 32'(driver_on), 32'h000c);
    thermal_shutdown_det <= 4'h2;
    settle();
    chk("tsd_off", 32'(driver_on), 32'h0000);
    send(16'h000c);
    chk("tsd_status", rx, 32'h0018);
    thermal_shutdown_det <= 4'h0;
    send(16'h0000);
    send(16'h0000);
    chk("tsd_clear", rx, 32'h0000);
    // Frozen enable: synchronisers and latches must hold
    ce <= 1'b0;
    par <= 4'hf;
    settle();
    chk("ce_hold", 32'(driver_on), 32'h0000);
    ce <= 1'b1;
    settle();
    chk("ce_run", 32'(driver_on), 32'h00f0);
    // Reset in mid-run clears both registers
    par <= 4'h0;
    send(16'hff0f);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk("rst_regs", {16'h0, open_load_en, driver_on}, 32'h0000);
    chk("rst_sdo_oe", 32'(sdo_oe), 32'h0);
    send(16'h0000);
    chk("rst_status", rx, 32'h0000);
    test_done();
  end

  // Roughly five times the expected run length
  initial
  begin
    repeat (40000) @(posedge mclk);
    fails++;
    test_done();
  end
endmodule : octal_driver_spi_frame_tb_top

// ---- sim/spi_host_model.sv ----
// Host model: mode 0 frames, LSB first, clock parked low.
// Assumes mclk from the bench; phases are counted in mclk cycles.
`timescale 1ns/1ps
module spi_host_model
(
  // Clock
  input  wire logic mclk,
  // Serial pins
  output logic      sclk,
  output logic      frame_select_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  initial
  begin
    sclk           = 1'b0;
    frame_select_n = 1'b1;
    sdi            = 1'b0;
  end

  // Sends n bits of tx; half sets the sclk phase, slow or prompt
  task automatic xfer(input logic [31:0] tx, input int n, input int half,
                      output logic [31:0] rx);
    rx = 32'h0000_0000;
    @(posedge mclk);
    frame_select_n <= 1'b0;
    repeat (6) @(posedge mclk);
    for (int i = 0; i < n; i++)
    begin
      sdi <= tx[i];
      repeat (half) @(posedge mclk);
      // Undriven output must not pass for data
      rx[i] = sdo_oe ? sdo : 1'bx;
      sclk <= 1'b1;
      repeat (half) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (half) @(posedge mclk);
    frame_select_n <= 1'b1;
    // Released line falls to its pull-down level
    sdi <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask : xfer
endmodule : spi_host_model
